/* File: common/audio_src_pkg.sv */
// Constants, codes and helpers for the serial audio source controller.
// Assumes a single 125 MHz system clock; no other party includes this.
package audio_src_pkg;

    // ==================================================================
    // Format codes driven on the three format select pins
    localparam logic [2:0] FMT_RJ16 = 3'h0;
    localparam logic [2:0] FMT_RJ18 = 3'h1;
    localparam logic [2:0] FMT_RJ20 = 3'h2;
    localparam logic [2:0] FMT_RJ24 = 3'h3;
    localparam logic [2:0] FMT_I2S = 3'h4;
    localparam logic [2:0] FMT_LEFT = 3'h5;

    // ==================================================================
    // Bit clocks per frame select period
    localparam logic [1:0] RATIO_32 = 2'h0;
    localparam logic [1:0] RATIO_48 = 2'h1;
    localparam logic [1:0] RATIO_64 = 2'h2;

    // ==================================================================
    // Gain codes: 0, 6, 12, 18 dB
    localparam logic [1:0] GAIN_0DB = 2'h0;
    localparam logic [1:0] GAIN_6DB = 2'h1;
    localparam logic [1:0] GAIN_12DB = 2'h2;
    localparam logic [1:0] GAIN_18DB = 2'h3;

    // ==================================================================
    // Widths and timing
    localparam int SAMPLE_W = 24;
    localparam int CLK_PERIOD_NS = 8;
    localparam int RESET_LOW_NS = 1000;
    localparam int RESET_LOW_CYC = (RESET_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BCLK_HALF_CYC = 10;
    localparam logic [6:0] RESET_CNT_INIT = 7'h00;
    localparam logic [5:0] POS_INIT = 6'h00;
    localparam logic [23:0] WORD_INIT = 24'h000000;

    // ==================================================================
    // Bit clocks in one frame
    function automatic logic [6:0] frame_len(input logic [1:0] ratio);
        case (ratio)
            RATIO_32: frame_len = 7'h20;
            RATIO_48: frame_len = 7'h30;
            default: frame_len = 7'h40;
        endcase
    endfunction : frame_len

    // Valid bits per word, never longer than the slot
    function automatic logic [5:0] word_len(input logic [2:0] fmt, input logic [5:0] slot);
        logic [5:0] wl;
        case (fmt)
            FMT_RJ16: wl = 6'h10;
            FMT_RJ18: wl = 6'h12;
            FMT_RJ20: wl = 6'h14;
            FMT_RJ24: wl = 6'h18;
            default: wl = (slot >= 6'h18) ? 6'h18 : 6'h10;
        endcase
        word_len = (wl > slot) ? slot : wl;
    endfunction : word_len

    // Slot position carrying the most significant bit
    function automatic logic [5:0] msb_pos(input logic [2:0] fmt, input logic [5:0] slot);
        if (fmt == FMT_I2S) begin
            msb_pos = 6'h01;
        end else if (fmt == FMT_LEFT) begin
            msb_pos = 6'h00;
        end else begin
            msb_pos = slot - word_len(fmt, slot);
        end
    endfunction : msb_pos

endpackage : audio_src_pkg

/* File: common/bclk_tick_if.sv */
// Tick bundle between the bit clock divider and the source controller.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
`default_nettype none
interface bclk_tick_if;
    logic run;
    logic fall;
    logic rise;
    modport gen (input run, output fall, output rise);
    modport use_ticks (output run, input fall, input rise);
endinterface : bclk_tick_if
`default_nettype wire

/* File: design/bclk_divider.sv */
// Bit clock divider: alternating one-cycle fall and rise enables.
// Assumes run is driven from the controller on the same clock.
`timescale 1ns/1ps
`default_nettype none
module bclk_divider #(
    parameter int HALF_CYC = audio_src_pkg::BCLK_HALF_CYC
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Tick bundle
    bclk_tick_if.gen tick
);
    import audio_src_pkg::*;

    logic [15:0] cnt_reg;
    logic [15:0] cnt_next;
    logic phase_reg;
    logic phase_next;
    logic fall_reg;
    logic fall_next;
    logic rise_reg;
    logic rise_next;

    // ==================================================================
    // Half period counter; first tick after run is always a fall
    always_comb begin
        cnt_next = cnt_reg;
        phase_next = phase_reg;
        fall_next = 1'b0;
        rise_next = 1'b0;
        if (!tick.run) begin
            cnt_next = 16'h0000;
            phase_next = 1'b0;
        end else if (cnt_reg == 16'(HALF_CYC - 1)) begin
            cnt_next = 16'h0000;
            phase_next = ~phase_reg;
            fall_next = ~phase_reg;
            rise_next = phase_reg;
        end else begin
            cnt_next = cnt_reg + 16'h0001;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_reg <= 16'h0000;
            phase_reg <= 1'b0;
            fall_reg <= 1'b0;
            rise_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            phase_reg <= phase_next;
            fall_reg <= fall_next;
            rise_reg <= rise_next;
        end
    end

    assign tick.fall = fall_reg;
    assign tick.rise = rise_reg;

endmodule : bclk_divider
`default_nettype wire

/* File: design/audio_source_ctrl.sv */
// Serial audio source: drives bit clock, frame select, two data lines,
// format and gain straps and the reset pin of a clock-slave receiver.
// Assumes samples come from logic on i_clk; pins go straight to the device.
//
// Overview of operation
// - I2S: frame select low for left word, high for right word.
// - Bit clock runs 32, 48 or 64 periods per frame only.
// - I2S: MSB one bit clock after frame select changes.
// - MSB first; data changes on falling, sampled on rising bit clock.
// - Justified modes: frame select high for left, low for right.
// - Left-justified: MSB in the same bit period as the frame select toggle.
// - Right-justified 24-bit at 64 bit clocks per frame: first data bit eight bit periods after toggle.
// - Right-justified: LSB always in the last bit period before the toggle.
// - Format pins: 000-011 right-justified 16/18/20/24, 100 I2S, 101 left-justified.
// - Format patterns 110 and 111 are never driven.
// - Format and gain pins stay unchanged while reset is high.
`timescale 1ns/1ps
`default_nettype none
module audio_source_ctrl #(
    parameter int HALF_CYC = audio_src_pkg::BCLK_HALF_CYC
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Configuration orders
    input wire logic i_apply,
    input wire logic i_stop,
    input wire logic [2:0] i_fmt,
    input wire logic [1:0] i_gain,
    input wire logic [1:0] i_ratio,
    // Sample stream
    input wire logic i_sample_valid,
    input wire logic [audio_src_pkg::SAMPLE_W-1:0] i_main_left,
    input wire logic [audio_src_pkg::SAMPLE_W-1:0] i_main_right,
    input wire logic [audio_src_pkg::SAMPLE_W-1:0] i_sub_left,
    input wire logic [audio_src_pkg::SAMPLE_W-1:0] i_sub_right,
    output logic o_sample_ready,
    // Status
    output logic o_busy,
    output logic o_refused,
    output logic o_underrun,
    // Device pins
    output logic o_dev_reset_n,
    output logic [2:0] o_fmt_sel,
    output logic [1:0] o_gain_sel,
    output logic o_bclk,
    output logic o_lrclk,
    output logic o_main_sdata,
    output logic o_sub_sdata
);
    import audio_src_pkg::*;

    typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_RUN} state_t;

    bclk_tick_if tick ();

    bclk_divider #(.HALF_CYC(HALF_CYC)) u_div (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .tick(tick)
    );

    state_t state_reg, state_next;
    logic [6:0] cnt_reg, cnt_next;
    logic [2:0] fmt_reg, fmt_next;
    logic [1:0] gain_reg, gain_next;
    logic [1:0] ratio_reg, ratio_next;
    logic rstn_reg, rstn_next;
    logic busy_reg, busy_next;
    logic refused_reg, refused_next;
    logic bclk_reg, bclk_next;
    logic lr_reg, lr_next;
    logic msd_reg, msd_next;
    logic ssd_reg, ssd_next;
    logic [5:0] pos_reg, pos_next;
    logic [23:0] ml_reg, ml_next, mr_reg, mr_next, sl_reg, sl_next, sr_reg, sr_next;
    logic [23:0] hml_reg, hml_next, hmr_reg, hmr_next, hsl_reg, hsl_next, hsr_reg, hsr_next;
    logic full_reg, full_next;
    logic ready_reg, ready_next;
    logic under_reg, under_next;
    logic [5:0] slot;
    logic [6:0] flen;
    logic left_level;

    // Bit of a word at a slot position, zero outside the word
    function automatic logic tx_bit(input logic [23:0] w, input logic [5:0] p,
                                    input logic [2:0] fmt, input logic [5:0] sl);
        logic [5:0] st;
        logic [5:0] k;
        st = msb_pos(fmt, sl);
        k = p - st;
        tx_bit = 1'b0;
        if (p >= st && k < word_len(fmt, sl)) begin
            tx_bit = w[23 - k];
        end
    endfunction : tx_bit

    assign flen = frame_len(ratio_reg);
    assign slot = flen[6:1];
    assign left_level = (fmt_reg == FMT_I2S) ? 1'b0 : 1'b1;

    // ==================================================================
    // Control sequence and serial framing
    always_comb begin
        logic [5:0] p;
        logic in_right;
        p = 6'h00;
        in_right = 1'b0;
        state_next = state_reg;
        cnt_next = cnt_reg;
        fmt_next = fmt_reg;
        gain_next = gain_reg;
        ratio_next = ratio_reg;
        rstn_next = rstn_reg;
        refused_next = 1'b0;
        under_next = 1'b0;
        bclk_next = bclk_reg;
        lr_next = lr_reg;
        msd_next = msd_reg;
        ssd_next = ssd_reg;
        pos_next = pos_reg;
        {ml_next, mr_next, sl_next, sr_next} = {ml_reg, mr_reg, sl_reg, sr_reg};
        {hml_next, hmr_next, hsl_next, hsr_next} = {hml_reg, hmr_reg, hsl_reg, hsr_reg};
        full_next = full_reg;
        case (state_reg)
            ST_IDLE: begin
                rstn_next = 1'b0;
                bclk_next = 1'b1;
                msd_next = bclk_reg ? 1'b0 : msd_reg;
                ssd_next = bclk_reg ? 1'b0 : ssd_reg;
                if (i_apply) begin
                    // Reserved formats and ratios never reach the pins
                    if (i_fmt[2:1] == 2'b11 || i_ratio == 2'b11) begin
                        refused_next = 1'b1;
                    end else begin
                        fmt_next = i_fmt;
                        gain_next = i_gain;
                        ratio_next = i_ratio;
                        cnt_next = RESET_CNT_INIT;
                        state_next = ST_SETUP;
                    end
                end
            end
            ST_SETUP: begin
                // Straps settle under reset before the releasing edge
                cnt_next = cnt_reg + 7'h01;
                pos_next = 6'(flen - 7'h01);
                lr_next = ~left_level;
                if (i_stop) begin
                    state_next = ST_IDLE;
                end else if (cnt_reg == 7'(RESET_LOW_CYC - 1)) begin
                    rstn_next = 1'b1;
                    state_next = ST_RUN;
                end
            end
            ST_RUN: begin
                if (i_stop) begin
                    rstn_next = 1'b0;
                    state_next = ST_IDLE;
                end else if (tick.fall) begin
                    bclk_next = 1'b0;
                    pos_next = (pos_reg == 6'(flen - 7'h01)) ? POS_INIT : pos_reg + 6'h01;
                    if (pos_next == POS_INIT) begin
                        // One sample set per frame select period
                        if (full_reg) begin
                            {ml_next, mr_next, sl_next, sr_next} = {hml_reg, hmr_reg, hsl_reg, hsr_reg};
                            full_next = 1'b0;
                        end else begin
                            {ml_next, mr_next, sl_next, sr_next} = {4{WORD_INIT}};
                            under_next = 1'b1;
                        end
                    end
                    in_right = (pos_next >= slot);
                    p = in_right ? pos_next - slot : pos_next;
                    lr_next = in_right ? ~left_level : left_level;
                    // Same position and format on both lines
                    msd_next = tx_bit(in_right ? mr_next : ml_next, p, fmt_reg, slot);
                    ssd_next = tx_bit(in_right ? sr_next : sl_next, p, fmt_reg, slot);
                end else if (tick.rise) begin
                    bclk_next = 1'b1;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
        if (i_sample_valid && ready_reg) begin
            {hml_next, hmr_next, hsl_next, hsr_next} = {i_main_left, i_main_right, i_sub_left, i_sub_right};
            full_next = 1'b1;
        end
        ready_next = ~full_next;
        busy_next = (state_next != ST_IDLE);
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state_reg <= ST_IDLE;
            cnt_reg <= RESET_CNT_INIT;
            fmt_reg <= FMT_I2S;
            gain_reg <= GAIN_0DB;
            ratio_reg <= RATIO_64;
            rstn_reg <= 1'b0;
            busy_reg <= 1'b0;
            refused_reg <= 1'b0;
            bclk_reg <= 1'b1;
            lr_reg <= 1'b0;
            msd_reg <= 1'b0;
            ssd_reg <= 1'b0;
            pos_reg <= POS_INIT;
            {ml_reg, mr_reg, sl_reg, sr_reg} <= {4{WORD_INIT}};
            {hml_reg, hmr_reg, hsl_reg, hsr_reg} <= {4{WORD_INIT}};
            full_reg <= 1'b0;
            ready_reg <= 1'b0;
            under_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            fmt_reg <= fmt_next;
            gain_reg <= gain_next;
            ratio_reg <= ratio_next;
            rstn_reg <= rstn_next;
            busy_reg <= busy_next;
            refused_reg <= refused_next;
            bclk_reg <= bclk_next;
            lr_reg <= lr_next;
            msd_reg <= msd_next;
            ssd_reg <= ssd_next;
            pos_reg <= pos_next;
            {ml_reg, mr_reg, sl_reg, sr_reg} <= {ml_next, mr_next, sl_next, sr_next};
            {hml_reg, hmr_reg, hsl_reg, hsr_reg} <= {hml_next, hmr_next, hsl_next, hsr_next};
            full_reg <= full_next;
            ready_reg <= ready_next;
            under_reg <= under_next;
        end
    end

    assign tick.run = (state_reg == ST_RUN);
    assign o_sample_ready = ready_reg;
    assign o_busy = busy_reg;
    assign o_refused = refused_reg;
    assign o_underrun = under_reg;
    assign o_dev_reset_n = rstn_reg;
    assign o_fmt_sel = fmt_reg;
    assign o_gain_sel = gain_reg;
    assign o_bclk = bclk_reg;
    assign o_lrclk = lr_reg;
    assign o_main_sdata = msd_reg;
    assign o_sub_sdata = ssd_reg;

    // ==================================================================
    // Checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    sequence left_start_s;
        tick.fall && !i_stop && state_reg == ST_RUN && pos_next == POS_INIT;
    endsequence
    sequence fall_at_s(logic [5:0] where);
        tick.fall && !i_stop && state_reg == ST_RUN && pos_next == where;
    endsequence

    i2s_left_low_a: assert property (left_start_s and fmt_reg == FMT_I2S |=> !o_lrclk)
        else $error("I2S left word without frame select low");
    just_left_high_a: assert property (left_start_s and fmt_reg != FMT_I2S |=> o_lrclk)
        else $error("Justified left word without frame select high");
    ratio_legal_a: assert property (o_dev_reset_n |-> ratio_reg != 2'b11 && flen[3:0] == 4'h0)
        else $error("Illegal bit clocks per frame");
    i2s_msb_a: assert property (fall_at_s(6'h01) and fmt_reg == FMT_I2S |=> o_main_sdata == ml_reg[23])
        else $error("I2S MSB not one bit after frame select change");
    stable_rise_a: assert property ($rose(o_bclk) |-> $stable(o_main_sdata) && $stable(o_lrclk))
        else $error("Data moved on a rising bit clock");
    left_msb_a: assert property (left_start_s and fmt_reg == FMT_LEFT |=> o_main_sdata == ml_reg[23])
        else $error("Left-justified MSB not with frame select toggle");
    right24_msb_a: assert property (fall_at_s(6'h08) and fmt_reg == FMT_RJ24 && ratio_reg == RATIO_64
                                 |=> o_main_sdata == ml_reg[23])
        else $error("Right-justified 24-bit MSB not eight bits after toggle");
    right_lsb_a: assert property (fall_at_s(slot - 6'h01) and fmt_reg[2] == 1'b0
                               |=> (o_main_sdata == ml_reg[24 - word_len(fmt_reg, slot)]) [*2])
        else $error("Right-justified LSB not in last bit before toggle");
    fmt_legal_a: assert property (o_dev_reset_n |-> o_fmt_sel[2:1] != 2'b11)
        else $error("Reserved format on pins");
    straps_hold_a: assert property (o_dev_reset_n && $past(o_dev_reset_n)
                                    |-> $stable(o_fmt_sel) && $stable(o_gain_sel))
        else $error("Straps changed while reset high");

endmodule : audio_source_ctrl
`default_nettype wire

/* File: testbench/audio_rx_model.sv */
// Behavioural clock-slave receiver that decodes the controller's device pins.
// Assumes it runs on the controller's system clock and samples bclk with it.
`timescale 1ns/1ps
`default_nettype none
module audio_rx_model (
    // Clock
    input wire logic i_clk,
    // Device pins
    input wire logic i_reset_n,
    input wire logic [2:0] i_fmt_sel,
    input wire logic [1:0] i_gain_sel,
    input wire logic i_bclk,
    input wire logic i_lrclk,
    input wire logic i_main_sdata,
    input wire logic i_sub_sdata,
    // Decoded words
    output logic o_valid,
    output logic [23:0] o_main_l,
    output logic [23:0] o_main_r,
    output logic [23:0] o_sub_l,
    output logic [6:0] o_bits,
    output logic [2:0] o_fmt,
    output logic [6:0] o_gain_db,
    output logic o_moved
);
    logic rst_q, b_q, lr_q, have_l, left_lvl;
    logic [63:0] sh_m, sh_s;
    logic [6:0] n, n_l, wl;
    logic [1:0] gain;

    // ==========================================
    // Word length and left level
    always_comb begin
        case (o_fmt)
            3'h0: wl = 7'h10;
            3'h1: wl = 7'h12;
            3'h2: wl = 7'h14;
            3'h3: wl = 7'h18;
            default: wl = (n >= 7'h18) ? 7'h18 : 7'h10;
        endcase
        if (wl > n) begin
            wl = n;
        end
        left_lvl = (o_fmt != 3'h4);
    end

    // Bits outside the word are never looked at
    function automatic logic [23:0] pick(input logic [63:0] sh);
        logic [6:0] sft;
        sft = (o_fmt == 3'h4) ? n - wl - 7'h1 : (o_fmt == 3'h5) ? n - wl : 7'h0;
        pick = 24'((sh >> sft) & ((64'h1 << wl) - 64'h1)) << (7'h18 - wl);
    endfunction : pick

    // ==========================================
    // Capture on bclk rising edges
    always @(posedge i_clk) begin
        rst_q <= i_reset_n;
        b_q <= i_bclk;
        o_valid <= 1'b0;
        if (!i_reset_n) begin
            have_l <= 1'b0;
        end else if (!rst_q) begin
            o_fmt <= i_fmt_sel;
            gain <= i_gain_sel;
            o_gain_db <= 7'(i_gain_sel) * 7'h06;
            o_moved <= 1'b0;
            lr_q <= i_lrclk;
            n <= 7'h0;
        end else begin
            if (i_fmt_sel != o_fmt || i_gain_sel != gain) begin
                o_moved <= 1'b1;
            end
            if (i_bclk && !b_q) begin
                lr_q <= i_lrclk;
                if (i_lrclk != lr_q) begin
                    n <= 7'h1;
                    sh_m <= {63'h0, i_main_sdata};
                    sh_s <= {63'h0, i_sub_sdata};
                    if (n != 7'h0 && lr_q == left_lvl) begin
                        o_main_l <= pick(sh_m);
                        o_sub_l <= pick(sh_s);
                        n_l <= n;
                        have_l <= 1'b1;
                    end else if (n != 7'h0 && have_l) begin
                        // Sub right word is dropped here
                        o_main_r <= pick(sh_m);
                        o_bits <= n_l + n;
                        o_valid <= 1'b1;
                    end
                end else begin
                    n <= n + 7'h1;
                    sh_m <= {sh_m[62:0], i_main_sdata};
                    sh_s <= {sh_s[62:0], i_sub_sdata};
                end
            end
        end
    end
endmodule : audio_rx_model
`default_nettype wire

/* File: testbench/tb_top.sv */
// Self-checking bench for the serial audio source controller.
// Assumes the receiver model decodes the device pins on the same clock.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import audio_src_pkg::*;
    typedef struct packed {
        logic [2:0] fmt;
        logic [1:0] ratio;
        logic [1:0] gain;
        logic [6:0] wl;
        logic [6:0] bits;
        logic [6:0] db;
    } row_t;
    localparam logic [23:0] ML = 24'hc3a5f1;
    localparam logic [23:0] MR = 24'h5a1e87;
    localparam logic [23:0] SL = 24'h96d2b4;
    localparam logic [23:0] SR = 24'h0f0f0f;
    logic i_clk, i_rst, i_apply, i_stop, i_sample_valid, seen;
    logic [2:0] i_fmt, o_fmt_sel, m_fmt;
    logic [1:0] i_gain, i_ratio, o_gain_sel;
    logic o_sample_ready, o_busy, o_refused, o_underrun, o_dev_reset_n;
    logic o_bclk, o_lrclk, o_main_sdata, o_sub_sdata, m_valid, m_moved;
    logic [23:0] m_main_l, m_main_r, m_sub_l, msk;
    logic [6:0] m_bits, m_gain_db;
    int err_total = 0;
    int cmp_count = 0;
    row_t rows [9];

    // ==========================================
    // Design and receiver model
    // Short bit clock keeps the run brief
    audio_source_ctrl #(.HALF_CYC(2)) dut_u (
        .i_clk(i_clk), .i_rst(i_rst), .i_apply(i_apply), .i_stop(i_stop), .i_fmt(i_fmt),
        .i_gain(i_gain), .i_ratio(i_ratio), .i_sample_valid(i_sample_valid),
        .i_main_left(ML), .i_main_right(MR), .i_sub_left(SL), .i_sub_right(SR),
        .o_sample_ready(o_sample_ready), .o_busy(o_busy), .o_refused(o_refused),
        .o_underrun(o_underrun), .o_dev_reset_n(o_dev_reset_n), .o_fmt_sel(o_fmt_sel),
        .o_gain_sel(o_gain_sel), .o_bclk(o_bclk), .o_lrclk(o_lrclk),
        .o_main_sdata(o_main_sdata), .o_sub_sdata(o_sub_sdata)
    );
    audio_rx_model rx_u (
        .i_clk(i_clk), .i_reset_n(o_dev_reset_n), .i_fmt_sel(o_fmt_sel), .i_gain_sel(o_gain_sel),
        .i_bclk(o_bclk), .i_lrclk(o_lrclk), .i_main_sdata(o_main_sdata), .i_sub_sdata(o_sub_sdata),
        .o_valid(m_valid), .o_main_l(m_main_l), .o_main_r(m_main_r), .o_sub_l(m_sub_l),
        .o_bits(m_bits), .o_fmt(m_fmt), .o_gain_db(m_gain_db), .o_moved(m_moved)
    );

    // ==========================================
    // Compare and sequencing tasks
    task automatic cmp_word(input logic [23:0] got, input logic [23:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_word
    task automatic cmp_flag(input logic [6:0] got, input logic [6:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_flag
    task automatic order(input logic [2:0] f, input logic [1:0] ra, input logic [1:0] g);
        i_fmt = f;
        i_ratio = ra;
        i_gain = g;
        i_apply = 1'b1;
        seen = 1'b0;
        repeat (4) begin
            @(negedge i_clk);
            i_apply = 1'b0;
            seen = seen | (o_refused === 1'b1);
        end
    endtask : order
    task automatic halt();
        @(negedge i_clk);
        i_stop = 1'b1;
        i_sample_valid = 1'b0;
        @(negedge i_clk);
        i_stop = 1'b0;
        repeat (3) @(negedge i_clk);
    endtask : halt
    task automatic wait_frame();
        int t;
        t = 0;
        @(negedge i_clk);
        while (m_valid !== 1'b1 && t < 2000) begin
            @(negedge i_clk);
            t++;
        end
    endtask : wait_frame
    task automatic give_verdict();
        $display("mismatches=%0d compares=%0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : give_verdict

    // ==========================================
    // Clock and watchdog
    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end
    initial begin
        #400000;
        err_total++;
        $display("CHECK FAILED t=%0t watchdog got=%h exp=%h", $time, 1'b0, 1'b1);
        give_verdict();
    end

    // ==========================================
    // Main sequence
    initial begin
        i_rst = 1'b1;
        i_apply = 1'b0;
        i_stop = 1'b0;
        i_sample_valid = 1'b0;
        i_fmt = FMT_I2S;
        i_gain = GAIN_0DB;
        i_ratio = RATIO_64;
        rows[0] = '{FMT_RJ16, RATIO_64, GAIN_0DB, 7'h10, 7'h40, 7'h00};
        rows[1] = '{FMT_RJ18, RATIO_48, GAIN_6DB, 7'h12, 7'h30, 7'h06};
        rows[2] = '{FMT_RJ20, RATIO_64, GAIN_12DB, 7'h14, 7'h40, 7'h0c};
        rows[3] = '{FMT_RJ24, RATIO_64, GAIN_18DB, 7'h18, 7'h40, 7'h12};
        rows[4] = '{FMT_RJ24, RATIO_32, GAIN_0DB, 7'h10, 7'h20, 7'h00};
        rows[5] = '{FMT_I2S, RATIO_64, GAIN_6DB, 7'h18, 7'h40, 7'h06};
        rows[6] = '{FMT_I2S, RATIO_64, GAIN_12DB, 7'h18, 7'h40, 7'h0c};
        rows[7] = '{FMT_LEFT, RATIO_48, GAIN_18DB, 7'h18, 7'h30, 7'h12};
        rows[8] = '{FMT_LEFT, RATIO_32, GAIN_0DB, 7'h10, 7'h20, 7'h00};
        repeat (8) @(negedge i_clk);
        i_rst = 1'b0;
        @(negedge i_clk);
        cmp_flag(7'(o_dev_reset_n), 7'h0);
        cmp_flag(7'(o_sample_ready), 7'h1);
        foreach (rows[k]) begin
            halt();
            i_sample_valid = 1'b1;
            order(rows[k].fmt, rows[k].ratio, rows[k].gain);
            // First frame may still carry the previous set
            wait_frame();
            wait_frame();
            msk = 24'hffffff << (7'h18 - rows[k].wl);
            cmp_flag(7'(m_valid), 7'h1);
            cmp_word(m_main_l, ML & msk);
            cmp_word(m_main_r, MR & msk);
            cmp_word(m_sub_l, SL & msk);
            cmp_flag(m_bits, rows[k].bits);
            cmp_flag(7'(m_fmt), 7'(rows[k].fmt));
            cmp_flag(m_gain_db, rows[k].db);
            cmp_flag(7'(m_moved), 7'h0);
        end
        // Order while running must leave the straps alone
        order(FMT_RJ16, RATIO_32, GAIN_6DB);
        cmp_flag(7'(o_fmt_sel), 7'(FMT_LEFT));
        cmp_flag(7'(seen), 7'h0);
        // Reserved patterns and a bad ratio
        for (int k = 0; k < 3; k++) begin
            halt();
            order((k == 2) ? FMT_I2S : 3'(6 + k), (k == 2) ? 2'h3 : RATIO_64, GAIN_6DB);
            cmp_flag(7'(seen), 7'h1);
            cmp_flag(7'(o_busy), 7'h0);
            cmp_flag(7'(o_fmt_sel), 7'(FMT_LEFT));
        end
        // Reset in mid-frame; no new set offered, so the second frame underruns
        halt();
        order(FMT_I2S, RATIO_48, GAIN_18DB);
        seen = 1'b0;
        repeat (700) begin
            @(negedge i_clk);
            seen = seen | (o_underrun === 1'b1);
        end
        cmp_flag(7'(seen), 7'h1);
        i_rst = 1'b1;
        @(negedge i_clk);
        cmp_flag(7'(o_dev_reset_n), 7'h0);
        cmp_flag(7'(o_bclk), 7'h1);
        i_rst = 1'b0;
        @(negedge i_clk);
        cmp_flag(7'(o_busy), 7'h0);
        give_verdict();
    end
endmodule : tb_top
`default_nettype wire
